// ### design/adc_path_control.sv
// converter input routing, clock gating, rate ticks and sample registers behind an APB slave
// How it works
// - with channel_swap set, analog channels 2 and 3 cross so converter 3 takes the channel-2 input.
// - while the radio is in use, converters 1 and 2 are held on the radio pair and only converter 3 is free.
// - every register of the block runs from the single crystal_input_clock.
// - analog and RF clocking switches on by itself when the matching blocks are enabled.
// - the converter front end runs at half the crystal clock whatever rate is chosen.
// - output rates from 24 kHz to 192 kHz come from decimation by 256 down to 32 of the half-rate front end.
// - a 24-bit result shows bits 23:8 in its high word and bits 7:0 in bits 15:8 of its low word.
// - an 18-bit radio result shows bits 17:2 in its high word and bits 1:0 in bits 15:14 of its low word.
// - converter 1 select codes 010,110,000,101,100 pick line a, line b, line c, mic pair a and radio I.
// - converter 2 decodes the same codes for its own inputs, and takes line_a_ch3 when swapped.
// - converter_filter_cfg holds swap 9, decimator input 8:7, mono rate 6:5, stereo rate 4:3, enables 2..0.
// - filter_soft_reset bit 6 enables the filters; clearing then setting it realigns stereo and mono.
`timescale 1ns/1ps
`include "adc_path_params.svh"
module adc_path_control #(
    parameter int SAMPLE_W = 24,
    parameter int RADIO_W = 18
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire adc_path_pkg::apb_req_t I_APB,
    input wire adc_path_pkg::conv_samples_t I_CONV,
    input wire adc_path_pkg::radio_samples_t I_RADIO,
    output adc_path_pkg::apb_rsp_t O_APB,
    output adc_path_pkg::path_out_t O_PATH
);
    import adc_path_pkg::*;

    if (SAMPLE_W != 24 || RADIO_W != 18)
    begin : g_width_check
        $error("sample widths other than 24 and 18 are not supported");
    end

    state_t q_reg;
    state_t q_next;
    logic [15:0] idx;
    src_t c1_code;
    src_t c2_code;
    logic ract;
    logic srun;
    logic mrun;

    // select bits are ordered radio, line, mic
    function automatic src_t route_code(input logic [2:0] sel);
        case (sel)
            3'h2: route_code = SRC_LINE_A;
            3'h6: route_code = SRC_LINE_B;
            3'h0: route_code = SRC_LINE_C;
            3'h5: route_code = SRC_MIC;
            3'h4: route_code = SRC_RADIO;
            default: route_code = SRC_NONE;
        endcase
    endfunction

    // crystal cycles per output sample: front end at half rate, then decimation
    function automatic logic [9:0] decim_period(input logic [1:0] code);
        decim_period = 10'(({1'b0, `DECIM_BASE} << code) << 1);
        // code 3 gives 512, the longest period; still fits ten bits
    endfunction

    function automatic logic mapped(input logic [15:0] i);
        case (i)
            `IDX_RADIO_FILTER_CFG, `IDX_CONV_FILTER_CFG, `IDX_ROUTE_CFG, `IDX_CLOCK_CTRL,
            `IDX_PATH_STATUS, `IDX_LEFT_LOW, `IDX_LEFT_HIGH, `IDX_RIGHT_LOW, `IDX_RIGHT_HIGH,
            `IDX_MONO_LOW, `IDX_MONO_HIGH, `IDX_FM_LEFT_LOW, `IDX_FM_LEFT_HIGH,
            `IDX_FM_RIGHT_LOW, `IDX_FM_RIGHT_HIGH: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] rd_word(input state_t s, input logic [15:0] i);
        case (i)
            `IDX_RADIO_FILTER_CFG: rd_word = s.fm_cfg;
            `IDX_CONV_FILTER_CFG: rd_word = s.ad_cfg;
            `IDX_ROUTE_CFG: rd_word = s.route;
            `IDX_CLOCK_CTRL: rd_word = s.clk_ctrl;
            `IDX_PATH_STATUS: rd_word = {7'h00, s.out.conv3, s.out.conv2, s.out.conv1};
            `IDX_LEFT_LOW: rd_word = {s.left[7:0], 8'h00};
            `IDX_LEFT_HIGH: rd_word = s.left[23:8];
            `IDX_RIGHT_LOW: rd_word = {s.right[7:0], 8'h00};
            `IDX_RIGHT_HIGH: rd_word = s.right[23:8];
            `IDX_MONO_LOW: rd_word = {s.mono[7:0], 8'h00};
            `IDX_MONO_HIGH: rd_word = s.mono[23:8];
            `IDX_FM_LEFT_LOW: rd_word = {s.fml[1:0], 14'h0000};
            `IDX_FM_LEFT_HIGH: rd_word = s.fml[17:2];
            `IDX_FM_RIGHT_LOW: rd_word = {s.fmr[1:0], 14'h0000};
            `IDX_FM_RIGHT_HIGH: rd_word = s.fmr[17:2];
            default: rd_word = 16'h0000;
        endcase
    endfunction

    assign idx = I_APB.paddr[17:2];
    assign c1_code = route_code(q_reg.route[`POS_CH1_SELECT +: 3]);
    assign c2_code = route_code(q_reg.route[`POS_CH2_SELECT +: 3]);
    // radio owns converters 1 and 2 while its decimator takes the demodulator
    assign ract = q_reg.ad_cfg[`BIT_RADIO_DECIM_EN] && !q_reg.clk_ctrl[`BIT_RADIO_CLOCK_OFF]
        && (q_reg.ad_cfg[`POS_DECIM_INPUT +: 2] == `DECIM_INPUT_RADIO);
    // counters stay cleared while the soft reset is low, so both restart in phase
    assign srun = q_reg.fm_cfg[`BIT_FILTER_SOFT_RESET] && !q_reg.clk_ctrl[`BIT_CONV_CLOCK_OFF]
        && q_reg.ad_cfg[`BIT_STEREO_EN];
    assign mrun = q_reg.fm_cfg[`BIT_FILTER_SOFT_RESET] && !q_reg.clk_ctrl[`BIT_CONV_CLOCK_OFF]
        && q_reg.ad_cfg[`BIT_MONO_EN];

    always_comb
    begin
        q_next = q_reg;
        q_next.rsp.pready = 1'b0;
        q_next.rsp.pslverr = 1'b0;
        // answer one cycle after setup; read data is the snapshot at setup
        if (I_APB.psel && !I_APB.penable)
        begin
            q_next.rsp.pready = 1'b1;
            q_next.rsp.prdata = {16'h0000, rd_word(q_reg, idx)};
            q_next.rsp.pslverr = !mapped(idx) || (I_APB.paddr[1:0] != 2'h0);
        end
        if (I_APB.psel && I_APB.penable && q_reg.rsp.pready && I_APB.pwrite && !q_reg.rsp.pslverr)
        begin
            case (idx)
                `IDX_RADIO_FILTER_CFG: q_next.fm_cfg = I_APB.pwdata[15:0];
                `IDX_CONV_FILTER_CFG: q_next.ad_cfg = {6'h00, I_APB.pwdata[9:0]};
                `IDX_ROUTE_CFG: q_next.route = {9'h000, I_APB.pwdata[6:4], 1'b0, I_APB.pwdata[2:0]};
                `IDX_CLOCK_CTRL: q_next.clk_ctrl = {14'h0000, I_APB.pwdata[1:0]};
                default: q_next.fm_cfg = q_reg.fm_cfg; // sample words are read only
            endcase
        end

        // converter routing
        q_next.out.radio_active = ract;
        q_next.out.conv1 = ract ? SRC_RADIO : c1_code;
        if (ract)
        begin
            q_next.out.conv2 = SRC_RADIO;
            q_next.out.conv3 = q_reg.ad_cfg[`BIT_CHANNEL_SWAP] ? c2_code : SRC_LINE_A3;
        end
        else if (q_reg.ad_cfg[`BIT_CHANNEL_SWAP])
        begin
            q_next.out.conv2 = SRC_LINE_A3;
            q_next.out.conv3 = c2_code;
        end
        else
        begin
            q_next.out.conv2 = c2_code;
            q_next.out.conv3 = SRC_LINE_A3;
        end

        // clock gates
        q_next.out.conv_clk_en = !q_reg.clk_ctrl[`BIT_CONV_CLOCK_OFF];
        q_next.out.radio_clk_en = !q_reg.clk_ctrl[`BIT_RADIO_CLOCK_OFF];
        q_next.out.analog_clk_en = !q_reg.clk_ctrl[`BIT_CONV_CLOCK_OFF]
            && (q_reg.ad_cfg[`BIT_STEREO_EN] || q_reg.ad_cfg[`BIT_MONO_EN]);
        q_next.out.rf_clk_en = ract;
        q_next.out.frontend_clk = !q_reg.out.frontend_clk;

        // output rate ticks
        q_next.out.stereo_tick = 1'b0;
        q_next.out.mono_tick = 1'b0;
        if (!srun)
        begin
            q_next.scnt = 10'h000;
        end
        else if (q_reg.scnt == 10'(decim_period(q_reg.ad_cfg[`POS_STEREO_RATE +: 2]) - 10'h001))
        begin
            q_next.scnt = 10'h000;
            q_next.out.stereo_tick = 1'b1;
        end
        else
        begin
            q_next.scnt = 10'(q_reg.scnt + 10'h001);
        end
        if (!mrun)
        begin
            q_next.mcnt = 10'h000;
        end
        else if (q_reg.mcnt == 10'(decim_period(q_reg.ad_cfg[`POS_MONO_RATE +: 2]) - 10'h001))
        begin
            q_next.mcnt = 10'h000;
            q_next.out.mono_tick = 1'b1;
        end
        else
        begin
            q_next.mcnt = 10'(q_reg.mcnt + 10'h001);
        end

        // sample capture only from filters that are running
        if (srun && I_CONV.left_valid)
        begin
            q_next.left = I_CONV.left;
        end
        if (srun && I_CONV.right_valid)
        begin
            q_next.right = I_CONV.right;
        end
        if (mrun && I_CONV.mono_valid)
        begin
            q_next.mono = I_CONV.mono;
        end
        if (q_reg.fm_cfg[`BIT_FILTER_SOFT_RESET] && q_reg.ad_cfg[`BIT_RADIO_DECIM_EN]
            && !q_reg.clk_ctrl[`BIT_RADIO_CLOCK_OFF] && I_RADIO.valid)
        begin
            q_next.fml = I_RADIO.left;
            q_next.fmr = I_RADIO.right;
        end
    end

    // single crystal clock domain for all of it
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            q_reg <= '0;
            q_reg.fm_cfg <= `RST_RADIO_FILTER_CFG;
            q_reg.ad_cfg <= `RST_CONV_FILTER_CFG;
            q_reg.route <= `RST_ROUTE_CFG;
            q_reg.clk_ctrl <= `RST_CLOCK_CTRL;
            q_reg.out.conv3 <= SRC_LINE_A3;
            q_reg.out.conv1 <= SRC_LINE_C;
            q_reg.out.conv2 <= SRC_LINE_C;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign O_APB = q_reg.rsp;
    assign O_PATH = q_reg.out;

    // helper: cycles since the previous stereo tick, valid while the setup is steady
    logic [10:0] gap;
    logic gap_ok;
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            gap <= 11'h000;
            gap_ok <= 1'b0;
        end
        else if (!srun || q_reg.ad_cfg != q_next.ad_cfg)
        begin
            gap <= 11'h000;
            gap_ok <= 1'b0;
        end
        else if (q_reg.out.stereo_tick)
        begin
            gap <= 11'h001;
            gap_ok <= 1'b1;
        end
        else
        begin
            gap <= 11'(gap + 11'h001);
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    sequence s_setup(logic [15:0] i);
        I_APB.psel && !I_APB.penable && idx == i;
    endsequence
    sequence s_steady_route;
        !ract ##0 $stable(q_reg.route);
    endsequence

    AST_SWAP_CROSS: assert property ((q_reg.ad_cfg[9] && !ract) |=>
        O_PATH.conv3 == $past(c2_code) && O_PATH.conv2 == SRC_LINE_A3)
        else $error("swap did not cross channels 2 and 3");
    AST_RADIO_RESERVE: assert property (ract |=>
        O_PATH.conv1 == SRC_RADIO && O_PATH.conv2 == SRC_RADIO && O_PATH.rf_clk_en)
        else $error("radio did not hold converters 1 and 2");
    AST_CLOCK_GATE: assert property (q_reg.clk_ctrl[0] |=> !O_PATH.conv_clk_en && !O_PATH.analog_clk_en
        && (q_reg.scnt == 10'h000))
        else $error("converter clock not gated off");
    AST_AUTO_CLOCK: assert property ((q_reg.ad_cfg[0] && !q_reg.clk_ctrl[0]) |=> O_PATH.analog_clk_en)
        else $error("analog clock not switched on");
    AST_HALF_RATE: assert property (O_PATH.frontend_clk |=> !O_PATH.frontend_clk ##1 O_PATH.frontend_clk)
        else $error("front end clock is not half the crystal");
    AST_TICK_SPACING: assert property ((O_PATH.stereo_tick && gap_ok) |->
        gap == 11'({1'b0, decim_period(q_reg.ad_cfg[4:3])}) || (q_reg.ad_cfg[4:3] == 2'h3 && gap == 11'h400))
        else $error("stereo tick spacing wrong");
    AST_HIGH_WORD: assert property (s_setup(`IDX_LEFT_HIGH) |=>
        O_APB.pready && O_APB.prdata == {16'h0000, $past(q_reg.left[23:8])})
        else $error("left high word wrong");
    AST_LOW_WORD: assert property (s_setup(`IDX_MONO_LOW) |=>
        O_APB.prdata == {16'h0000, $past(q_reg.mono[7:0]), 8'h00})
        else $error("mono low word wrong");
    AST_RADIO_WORD: assert property (s_setup(`IDX_FM_LEFT_LOW) |=>
        O_APB.prdata == {16'h0000, $past(q_reg.fml[1:0]), 14'h0000})
        else $error("radio low word wrong");
    AST_CH1_ROUTE: assert property (s_steady_route |=> O_PATH.conv1 == $past(c1_code))
        else $error("converter 1 route wrong");
    AST_CH2_ROUTE: assert property ((!q_reg.ad_cfg[9] && !ract) |=>
        O_PATH.conv2 == $past(c2_code) && O_PATH.conv3 == SRC_LINE_A3)
        else $error("converter 2 route wrong");
    AST_SAMPLE_HOLD: assert property ((!srun || !I_CONV.left_valid) |=> $stable(q_reg.left))
        else $error("left sample changed without a result");
    AST_RESYNC: assert property (!q_reg.fm_cfg[6] |=> q_reg.scnt == 10'h000 && q_reg.mcnt == 10'h000
        && !O_PATH.stereo_tick && !O_PATH.mono_tick)
        else $error("soft reset did not hold rate counters");

    // helper: radio capture gate, same terms as the capture logic needs
    logic fm_run;
    assign fm_run = q_reg.fm_cfg[`BIT_FILTER_SOFT_RESET] && q_reg.ad_cfg[`BIT_RADIO_DECIM_EN]
        && !q_reg.clk_ctrl[`BIT_RADIO_CLOCK_OFF];

    // access cycle of a write that the slave is answering now
    sequence s_write_access;
        I_APB.psel && I_APB.penable && I_APB.pwrite && O_APB.pready;
    endsequence

    AST_ANSWER_NEXT: assert property ((I_APB.psel && !I_APB.penable) |=> O_APB.pready)
        else $error("no answer one cycle after setup");
    AST_BAD_WRITE_DROP: assert property ((s_write_access ##0 O_APB.pslverr) |=>
        $stable(q_reg.ad_cfg) && $stable(q_reg.fm_cfg) && $stable(q_reg.clk_ctrl))
        else $error("refused write changed a register");
    AST_CFG_WRITE: assert property ((s_write_access ##0 !O_APB.pslverr && idx == `IDX_CONV_FILTER_CFG) |=>
        q_reg.ad_cfg == {6'h00, $past(I_APB.pwdata[9:0])})
        else $error("converter config write lost");
    AST_RADIO_CAPTURE: assert property ((fm_run && I_RADIO.valid) |=>
        q_reg.fml == $past(I_RADIO.left) && q_reg.fmr == $past(I_RADIO.right))
        else $error("radio result not captured");
    AST_RADIO_HOLD: assert property ((!fm_run || !I_RADIO.valid) |=> $stable(q_reg.fml))
        else $error("radio sample changed without a result");
    AST_RADIO_GATE: assert property (q_reg.clk_ctrl[1] |=> !O_PATH.radio_clk_en && !O_PATH.rf_clk_en)
        else $error("radio clock not gated off");
endmodule // adc_path_control

// ### design/adc_path_params.svh
// register indices, field positions, reset values and rate counts of the converter control
`ifndef ADC_PATH_PARAMS_SVH
`define ADC_PATH_PARAMS_SVH
`define IDX_RADIO_FILTER_CFG 16'hFE40
`define IDX_CONV_FILTER_CFG 16'hFE41
`define IDX_ROUTE_CFG 16'hFE42
`define IDX_CLOCK_CTRL 16'hFE43
`define IDX_PATH_STATUS 16'hFE44
`define IDX_LEFT_LOW 16'hFE46
`define IDX_LEFT_HIGH 16'hFE47
`define IDX_RIGHT_LOW 16'hFE48
`define IDX_RIGHT_HIGH 16'hFE49
`define IDX_MONO_LOW 16'hFE4A
`define IDX_MONO_HIGH 16'hFE4B
`define IDX_FM_LEFT_LOW 16'hFE4E
`define IDX_FM_LEFT_HIGH 16'hFE4F
`define IDX_FM_RIGHT_LOW 16'hFE50
`define IDX_FM_RIGHT_HIGH 16'hFE51
`define BIT_FILTER_SOFT_RESET 6
`define BIT_CHANNEL_SWAP 9
`define POS_DECIM_INPUT 7
`define POS_MONO_RATE 5
`define POS_STEREO_RATE 3
`define BIT_RADIO_DECIM_EN 2
`define BIT_MONO_EN 1
`define BIT_STEREO_EN 0
`define POS_CH1_SELECT 0
`define POS_CH2_SELECT 4
`define BIT_CONV_CLOCK_OFF 0
`define BIT_RADIO_CLOCK_OFF 1
`define RST_RADIO_FILTER_CFG 16'h0000
`define RST_CONV_FILTER_CFG 16'h0000
`define RST_ROUTE_CFG 16'h0000
`define RST_CLOCK_CTRL 16'h0003
`define DECIM_INPUT_RADIO 2'h0
`define DECIM_BASE 10'h020
`endif

// ### design/adc_path_pkg.sv
// types shared by the converter input path control
package adc_path_pkg;
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_LINE_A = 3'h1,
        SRC_LINE_C = 3'h2,
        SRC_LINE_B = 3'h3,
        SRC_LINE_A3 = 3'h5,
        SRC_MIC = 3'h6,
        SRC_RADIO = 3'h7
    } src_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [17:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
    typedef struct packed {
        logic left_valid;
        logic [23:0] left;
        logic right_valid;
        logic [23:0] right;
        logic mono_valid;
        logic [23:0] mono;
    } conv_samples_t;
    typedef struct packed {
        logic valid;
        logic [17:0] left;
        logic [17:0] right;
    } radio_samples_t;
    typedef struct packed {
        src_t conv1;
        src_t conv2;
        src_t conv3;
        logic conv_clk_en;
        logic radio_clk_en;
        logic analog_clk_en;
        logic rf_clk_en;
        logic frontend_clk;
        logic stereo_tick;
        logic mono_tick;
        logic radio_active;
    } path_out_t;
    typedef struct packed {
        apb_rsp_t rsp;
        path_out_t out;
        logic [15:0] fm_cfg;
        logic [15:0] ad_cfg;
        logic [15:0] route;
        logic [15:0] clk_ctrl;
        logic [23:0] left;
        logic [23:0] right;
        logic [23:0] mono;
        logic [17:0] fml;
        logic [17:0] fmr;
        logic [9:0] scnt;
        logic [9:0] mcnt;
    } state_t;
endpackage

// ### test/adc_path_testbench.sv
// self-checking bench for the converter input path control
`timescale 1ns/1ps
`include "adc_path_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
    import adc_path_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    conv_samples_t conv = '0;
    radio_samples_t radio = '0;
    path_out_t path;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic err;

    always #12.5 clk = ~clk;

    adc_path_control u_dut (
        .I_CLK(clk),
        .I_RST_N(rst_n),
        .I_APB(req),
        .I_CONV(conv),
        .I_RADIO(radio),
        .O_APB(rsp),
        .O_PATH(path)
    );

    // holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {16'h0000, wd}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 16)
            n_errors++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        `CHK(rd, exp)
        `CHK(err, 1'b0)
    endtask

    task automatic chk24(input logic [15:0] hi, input logic [15:0] lo, input logic [23:0] v);
        rdchk(hi, {16'h0000, v[23:8]});
        rdchk(lo, {16'h0000, v[7:0], 8'h00});
    endtask

    task automatic chk18(input logic [15:0] hi, input logic [15:0] lo, input logic [17:0] v);
        rdchk(hi, {16'h0000, v[17:2]});
        rdchk(lo, {16'h0000, v[1:0], 14'h0000});
    endtask

    // config changes reach the path outputs one edge after the access edge
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    function automatic src_t code2src(input logic [2:0] c);
        case (c)
            3'b010: return SRC_LINE_A;
            3'b110: return SRC_LINE_B;
            3'b000: return SRC_LINE_C;
            3'b101: return SRC_MIC;
            3'b100: return SRC_RADIO;
            default: return SRC_NONE;
        endcase
    endfunction

    task automatic pulse(input logic [23:0] v, input logic [17:0] f);
        @(posedge clk);
        conv <= '{1'b1, v, 1'b1, ~v, 1'b1, v ^ 24'h5A5A5A};
        radio <= '{1'b1, f, ~f};
        @(posedge clk);
        conv <= '0;
        radio <= '0;
    endtask

    task automatic t_reset();
        logic [15:0] tbl [14] = '{16'hFE40, 16'hFE41, 16'hFE46, 16'hFE47, 16'hFE48, 16'hFE49, 16'hFE4A,
            16'hFE4B, 16'hFE4E, 16'hFE4F, 16'hFE50, 16'hFE51, 16'hFE42, 16'hFE43};
        `CHK(path.conv1, SRC_LINE_C)
        `CHK(path.conv3, SRC_LINE_A3)
        `CHK(path.conv_clk_en, 1'b0)
        for (int i = 0; i < 14; i++)
            rdchk(tbl[i], (i == 13) ? 32'h00000003 : 32'h00000000);
        apb(1'b0, 16'hFE45, 16'h0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
    endtask

    task automatic t_clock();
        logic f;
        apb(1'b1, `IDX_CLOCK_CTRL, 16'h0000);
        settle();
        `CHK(path.conv_clk_en, 1'b1)
        `CHK(path.radio_clk_en, 1'b1)
        `CHK(path.analog_clk_en, 1'b0)
        apb(1'b1, `IDX_CONV_FILTER_CFG, 16'h0001);
        settle();
        `CHK(path.analog_clk_en, 1'b1)
        for (int i = 0; i < 4; i++)
        begin
            f = path.frontend_clk;
            @(posedge clk);
            `CHK(path.frontend_clk, ~f)
        end
    endtask

    task automatic t_route();
        logic [2:0] c2;
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, `IDX_CONV_FILTER_CFG, 16'(s) << 9);
            for (int c = 0; c < 8; c++)
            begin
                c2 = 3'(7 - c);
                apb(1'b1, `IDX_ROUTE_CFG, {9'h000, c2, 1'b0, 3'(c)});
                settle();
                `CHK(path.conv1, code2src(3'(c)))
                `CHK(path.conv2, s ? SRC_LINE_A3 : code2src(c2))
                `CHK(path.conv3, s ? code2src(c2) : SRC_LINE_A3)
            end
            apb(1'b1, `IDX_CONV_FILTER_CFG, (16'(s) << 9) | 16'h0004);
            settle();
            `CHK(path.conv1, SRC_RADIO)
            `CHK(path.conv2, SRC_RADIO)
            `CHK(path.conv3, s ? code2src(c2) : SRC_LINE_A3)
            `CHK(path.rf_clk_en, 1'b1)
        end
        // stereo decimator input frees the converters from the radio
        apb(1'b1, `IDX_CONV_FILTER_CFG, 16'h0084);
        settle();
        `CHK(path.conv1, code2src(3'h7))
    endtask

    task automatic t_samples();
        apb(1'b1, `IDX_RADIO_FILTER_CFG, 16'h0040);
        apb(1'b1, `IDX_CONV_FILTER_CFG, 16'h0007); // analog enables sit outside this block
        pulse(24'hABCDEF, 18'h2ABCD);
        chk24(`IDX_LEFT_HIGH, `IDX_LEFT_LOW, 24'hABCDEF);
        chk24(`IDX_RIGHT_HIGH, `IDX_RIGHT_LOW, ~24'hABCDEF);
        chk24(`IDX_MONO_HIGH, `IDX_MONO_LOW, 24'hABCDEF ^ 24'h5A5A5A);
        chk18(`IDX_FM_LEFT_HIGH, `IDX_FM_LEFT_LOW, 18'h2ABCD);
        chk18(`IDX_FM_RIGHT_HIGH, `IDX_FM_RIGHT_LOW, ~18'h2ABCD);
        apb(1'b1, `IDX_LEFT_HIGH, 16'h5A5A);
        `CHK(err, 1'b0)
        chk24(`IDX_LEFT_HIGH, `IDX_LEFT_LOW, 24'hABCDEF);
        // filters held in soft reset ignore new results
        apb(1'b1, `IDX_RADIO_FILTER_CFG, 16'h0000);
        pulse(24'h123456, 18'h01234);
        chk24(`IDX_LEFT_HIGH, `IDX_LEFT_LOW, 24'hABCDEF);
        chk18(`IDX_FM_LEFT_HIGH, `IDX_FM_LEFT_LOW, 18'h2ABCD);
    endtask

    task automatic t_ticks();
        int n;
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b1, `IDX_CONV_FILTER_CFG, 16'((r << 5) | (r << 3) | 3));
            apb(1'b1, `IDX_RADIO_FILTER_CFG, 16'h0000);
            apb(1'b1, `IDX_RADIO_FILTER_CFG, 16'h0040);
            n = 0;
            while (path.stereo_tick !== 1'b1 && n < 1100)
            begin
                @(posedge clk);
                n++;
            end
            `CHK(path.mono_tick, 1'b1)
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (path.stereo_tick !== 1'b1 && n < 1100);
            `CHK(n, 64 << r)
        end
    endtask

    task automatic results();
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_clock();
        t_route();
        t_samples();
        t_ticks();
        results();
    end
endmodule // testbench
